/* dso_output_block.sv */
/*
  Output stage of a time-of-flight depth sensor: programmable frame markers,
  a serial link of three data pairs with bit and pixel clock pairs, and a
  16-lane double-data-rate parallel link, each frame-ID led per quad.
  Assumes pixel taps, sync events and settings arrive on sys_clk.
*/
// What this block does
// (R1) Drive frame, sub-frame, quad and row markers at programmable delays.
// (R2) Offer serial and parallel links; carry pixels on the configured one.
// (R3) Serial mode uses three data pairs plus one pixel clock pair; the code also drives a bit clock pair.
// (R4) First and second serial pairs carry tap A minus tap B.
// (R5) Each serial difference value is a twelve-bit word.
// (R6) Pixel clock low for the first six bits, high for the last six.
// (R7) Host finds word boundaries from the pixel clock transitions.
// (R8) Serial bits go in pairs: even bit, then next odd bit, per interval.
// (R9) Parallel data changes on both edges of the output clock.
// (R10) Parallel output clock runs at the system clock frequency.
// (R11) After each vertical sync start a frame-ID word leads the pixels.
// (R12) Frame-ID holds 01010101, then sub-frame number, then quad number.
// (R13) Frame-ID uses the same lanes and clocking as pixel samples.
`timescale 1ns/1ps
`default_nettype none

module dso_output_block
  import dso_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 clk_en,
  // Configuration
  input  wire logic                 serial_sel,
  input  wire logic [DLY_W-1:0]     frame_mark_delay,
  input  wire logic [DLY_W-1:0]     subframe_mark_delay,
  input  wire logic [DLY_W-1:0]     quad_mark_delay,
  input  wire logic [DLY_W-1:0]     row_mark_delay,
  // Timing events
  input  wire logic                 frame_start_in,
  input  wire logic                 subframe_start_in,
  input  wire logic                 vertical_sync,
  input  wire logic                 row_start_in,
  input  wire logic [FID_NUM_W-1:0] subframe_number,
  input  wire logic [FID_NUM_W-1:0] quad_number,
  // Pixel source
  input  wire logic                 pix_valid,
  output logic                      pix_ready,
  input  wire logic [WORD_W-1:0]    tap_a0,
  input  wire logic [WORD_W-1:0]    tap_b0,
  input  wire logic [WORD_W-1:0]    tap_a1,
  input  wire logic [WORD_W-1:0]    tap_b1,
  input  wire logic [WORD_W-1:0]    aux_word,
  // Markers
  output logic                      frame_sync_out,
  output logic                      subframe_sync_out,
  output logic                      quad_sync_out,
  output logic                      row_sync_out,
  // Serial link
  output logic                      diff_data_pair_a_p,
  output logic                      diff_data_pair_a_n,
  output logic                      diff_data_pair_b_p,
  output logic                      diff_data_pair_b_n,
  output logic                      aux_data_pair_p,
  output logic                      aux_data_pair_n,
  output logic                      bit_clk_pair_p,
  output logic                      bit_clk_pair_n,
  output logic                      pix_clk_pair_p,
  output logic                      pix_clk_pair_n,
  // Parallel link
  output logic [PAR_W-1:0]          par_data_out,
  output logic                      par_clk_out
);

  logic                         rst_meta_ff;
  logic                         rst_q;
  dso_state_t                   s;
  dso_state_t                   nxt_s;
  logic [WORD_W-1:0]            diff_data_pair_a;
  logic [WORD_W-1:0]            diff_data_pair_b;
  logic                         vs_rise;
  logic                         fid_send;
  logic                         switching;
  logic [NUM_MARK-1:0]          mark_evt;
  logic [NUM_MARK-1:0][DLY_W-1:0] mark_dly;
  logic [SER_LANES+1:0]         ser_q;
  logic [PAR_W:0]               par_q;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_ff <= 1'b0;
      rst_q       <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_q       <= rst_meta_ff;
    end
  end

  // Tap difference, wraps in twelve bits
  assign diff_data_pair_a = tap_a0 - tap_b0;  // see (R4)
  assign diff_data_pair_b = tap_a1 - tap_b1;  // see (R4)

  assign vs_rise   = vertical_sync && !s.vs_d;
  assign switching = (s.mode_req != s.mode);

  // Marker events and delays by index
  assign mark_evt[MK_FRAME] = frame_start_in;
  assign mark_evt[MK_SUBF]  = subframe_start_in;
  assign mark_evt[MK_QUAD]  = vertical_sync;
  assign mark_evt[MK_ROW]   = row_start_in;
  assign mark_dly[MK_FRAME] = frame_mark_delay;
  assign mark_dly[MK_SUBF]  = subframe_mark_delay;
  assign mark_dly[MK_QUAD]  = quad_mark_delay;
  assign mark_dly[MK_ROW]   = row_mark_delay;

  // Source handshake: frame-ID first, serial takes one word per six cycles
  always_comb
  begin
    fid_send  = 1'b0;
    pix_ready = 1'b0;
    if (clk_en)
    begin
      if (s.mode == DSO_SER)
      begin
        fid_send  = (s.phase == PH_LAST) && s.fid_pend && !switching;   // see (R11)
        pix_ready = (s.phase == PH_LAST) && !s.fid_pend && !switching;
      end
      else
      begin
        // Switch cycle carries zeros, so the frame-ID waits for the new link
        fid_send  = s.fid_pend && !switching;                            // see (R11)
        pix_ready = !s.fid_pend && !switching;
      end
    end
  end

  // Next state of the whole block
  always_comb
  begin
    nxt_s      = s;
    nxt_s.vs_d = vertical_sync;

    // Frame-ID capture; a new sync start beats a send in the same cycle
    if (vs_rise)
    begin
      nxt_s.fid_word = {FID_PAT, subframe_number, quad_number};  // see (R12)
      nxt_s.mode_req = serial_sel ? DSO_SER : DSO_PAR;           // see (R2)
    end
    nxt_s.fid_pend = vs_rise || (s.fid_pend && !fid_send);        // see (R11)

    // Marker delay lines
    for (int i = 0; i < NUM_MARK; i++)
    begin
      nxt_s.hist[i]  = {s.hist[i][HIST_W-2:0], mark_evt[i]};
      nxt_s.marks[i] = nxt_s.hist[i][mark_dly[i]];                // see (R1)
    end

    // Defaults: links quiet
    nxt_s.ser_rise = '0;
    nxt_s.ser_fall = '0;
    nxt_s.pclk     = 1'b0;
    nxt_s.bclk     = 1'b0;
    nxt_s.par_rise = '0;
    nxt_s.par_fall = '0;
    nxt_s.par_ck   = 1'b0;

    if (s.mode == DSO_SER)
    begin
      // Even bit in high half, odd bit in low half
      nxt_s.ser_rise = {s.word_c[2*s.phase], s.word_b[2*s.phase],
                        s.word_a[2*s.phase]};                     // see (R8)
      nxt_s.ser_fall = {s.word_c[2*s.phase+1], s.word_b[2*s.phase+1],
                        s.word_a[2*s.phase+1]};                   // see (R8)
      nxt_s.pclk     = (s.phase >= PH_HIGH);                      // see (R6)
      nxt_s.bclk     = 1'b1;                                      // see (R3)
      if (s.phase == PH_LAST)
      begin
        nxt_s.phase  = PH_FIRST;
        nxt_s.word_a = '0;
        nxt_s.word_b = '0;
        nxt_s.word_c = '0;
        if (switching)
          nxt_s.mode = s.mode_req;
        else if (fid_send)
        begin
          // Frame-ID split over the two difference pairs
          nxt_s.word_a = s.fid_word[WORD_W-1:0];                  // see (R13)
          nxt_s.word_b = WORD_W'(s.fid_word >> WORD_W);           // see (R13)
        end
        else if (pix_valid && pix_ready)
        begin
          nxt_s.word_a = diff_data_pair_a;                                   // see (R4) (R5)
          nxt_s.word_b = diff_data_pair_b;                                   // see (R4) (R5)
          nxt_s.word_c = aux_word;
        end
      end
      else
        nxt_s.phase = s.phase + 3'h1;
    end
    else
    begin
      // Parallel: a sample pair per cycle, clock follows sys_clk
      nxt_s.phase  = PH_FIRST;
      nxt_s.word_a = '0;
      nxt_s.word_b = '0;
      nxt_s.word_c = '0;
      nxt_s.par_ck = 1'b1;                                        // see (R10)
      if (fid_send)
      begin
        nxt_s.par_rise = s.fid_word;                              // see (R13)
        nxt_s.par_fall = s.fid_word;                              // see (R13)
      end
      else if (pix_valid && pix_ready)
      begin
        nxt_s.par_rise = PAR_W'(diff_data_pair_a);                           // see (R9)
        nxt_s.par_fall = PAR_W'(diff_data_pair_b);                           // see (R9)
      end
      if (switching)
        nxt_s.mode = s.mode_req;
    end
  end

  // Single state register, frozen while the enable is low
  always_ff @(posedge sys_clk or negedge rst_q)
  begin
    if (!rst_q)
      s <= STATE_RST;
    else if (clk_en)
      s <= nxt_s;
  end

  // Serial pin cells: a, b, aux, bit clock, pixel clock
  dso_ddr_out #(.W(SER_LANES + 2)) u_ser_ddr (
    .sys_clk (sys_clk),
    .rst_n   (rst_q),
    .clk_en  (clk_en),
    .d_rise  ({s.pclk, s.bclk, s.ser_rise}),
    .d_fall  ({s.pclk, 1'b0, s.ser_fall}),
    .q       (ser_q)
  );

  // Parallel pin cells: clock on top, data below
  dso_ddr_out #(.W(PAR_W + 1)) u_par_ddr (
    .sys_clk (sys_clk),
    .rst_n   (rst_q),
    .clk_en  (clk_en),
    .d_rise  ({s.par_ck, s.par_rise}),
    .d_fall  ({1'b0, s.par_fall}),
    .q       (par_q)
  );

  // Pin mapping
  assign diff_data_pair_a_p = ser_q[0];
  assign diff_data_pair_a_n = ~ser_q[0];
  assign diff_data_pair_b_p = ser_q[1];
  assign diff_data_pair_b_n = ~ser_q[1];
  assign aux_data_pair_p    = ser_q[2];
  assign aux_data_pair_n    = ~ser_q[2];
  assign bit_clk_pair_p     = ser_q[3];
  assign bit_clk_pair_n     = ~ser_q[3];
  assign pix_clk_pair_p     = ser_q[4];
  assign pix_clk_pair_n     = ~ser_q[4];
  assign par_data_out       = par_q[PAR_W-1:0];
  assign par_clk_out        = par_q[PAR_W];
  assign frame_sync_out     = s.marks[MK_FRAME];
  assign subframe_sync_out  = s.marks[MK_SUBF];
  assign quad_sync_out      = s.marks[MK_QUAD];
  assign row_sync_out       = s.marks[MK_ROW];

  // Checks, all on sys_clk with the enable held high
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_q || !clk_en);

  sequence par_take_s;
    pix_valid && pix_ready && s.mode == DSO_PAR;
  endsequence
  sequence ser_take_s;
    pix_valid && pix_ready && s.mode == DSO_SER;
  endsequence
  sequence row_mark_s;
    (row_start_in && row_mark_delay == 4'h2) ##1 (row_mark_delay == 4'h2) [*2];
  endsequence

  row_mark_pos_a: assert property (row_mark_s |=> row_sync_out)  // see (R1)
    else $error("row marker not at programmed delay");
  link_idle_a: assert property (                                 // see (R2)
      s.mode == DSO_SER && $past(s.mode) == DSO_SER |-> s.par_rise == '0 && !s.par_ck)
    else $error("parallel lanes active in serial mode");
  pix_clk_shape_a: assert property (                             // see (R6)
      $rose(s.pclk) |-> s.pclk [*3] ##1 !s.pclk)
    else $error("pixel clock high not three intervals");
  ser_pair_bits_a: assert property (                             // see (R8)
      ser_take_s |-> ##2 s.ser_rise[0] == $past(diff_data_pair_a[0], 2)
                         && s.ser_fall[0] == $past(diff_data_pair_a[1], 2)
                         && s.ser_rise[1] == $past(diff_data_pair_b[0], 2))
    else $error("serial bit pair order wrong");
  ser_word_hold_a: assert property (                             // see (R5)
      ser_take_s |=> s.word_a == $past(diff_data_pair_a) ##6 s.pclk == 1'b1)
    else $error("serial word not twelve bits long");
  par_ddr_data_a: assert property (                              // see (R9)
      par_take_s |=> s.par_rise == PAR_W'($past(diff_data_pair_a))
                     && s.par_fall == PAR_W'($past(diff_data_pair_b)))
    else $error("parallel edges carry wrong data");
  par_clk_run_a: assert property (                               // see (R10)
      s.mode == DSO_PAR |=> s.par_ck || s.mode == DSO_SER)
    else $error("parallel clock stopped");
  fid_first_a: assert property (                                 // see (R11)
      (vs_rise && s.mode == DSO_PAR && !serial_sel) ##1 (s.mode == DSO_PAR && !switching)
      |-> !pix_ready ##1 s.par_rise[PAR_W-1:8] == FID_PAT)
    else $error("frame-ID not first after sync");
  fid_fields_a: assert property (                                // see (R12)
      vs_rise |=> s.fid_word == {FID_PAT, $past(subframe_number), $past(quad_number)})
    else $error("frame-ID fields wrong");
  fid_clear_a: assert property ($fell(s.fid_pend) |-> $past(fid_send))  // see (R11)
    else $error("frame-ID dropped without send");

endmodule : dso_output_block

`default_nettype wire

/* dso_pkg.sv */
/*
  Shared constants and types for the depth sensor output block: word widths,
  frame-ID layout, serial word phasing, marker history depth, reset values.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package dso_pkg;

  // Link selection
  typedef enum logic {
    DSO_PAR,
    DSO_SER
  } dso_mode_t;

  localparam int unsigned WORD_W    = 12;     // Serial pixel word
  localparam int unsigned PAR_W     = 16;     // Parallel lanes
  localparam int unsigned SER_LANES = 3;      // Serial data pairs
  localparam int unsigned HIST_W    = 16;     // Marker delay history
  localparam int unsigned DLY_W     = 4;      // Marker delay field
  localparam int unsigned NUM_MARK  = 4;      // Frame, sub-frame, quad, row
  localparam int unsigned PH_W      = 3;

  // Serial phase: six bit intervals of two bits each
  localparam logic [PH_W-1:0] PH_FIRST  = 3'h0;
  localparam logic [PH_W-1:0] PH_HIGH   = 3'h3;  // Pixel clock high from here
  localparam logic [PH_W-1:0] PH_LAST   = 3'h5;

  // Frame-ID word layout
  localparam logic [7:0] FID_PAT    = 8'h55;     // Fixed pattern, bits 15..8
  localparam int unsigned FID_NUM_W = 4;         // Sub-frame and quad fields

  // Marker indices
  localparam int unsigned MK_FRAME = 0;
  localparam int unsigned MK_SUBF  = 1;
  localparam int unsigned MK_QUAD  = 2;
  localparam int unsigned MK_ROW   = 3;

  localparam dso_mode_t MODE_RST = DSO_PAR;

  // Whole state of the output block
  typedef struct packed {
    dso_mode_t                         mode;
    dso_mode_t                         mode_req;
    logic [PH_W-1:0]                   phase;
    logic [WORD_W-1:0]                 word_a;
    logic [WORD_W-1:0]                 word_b;
    logic [WORD_W-1:0]                 word_c;
    logic [SER_LANES-1:0]              ser_rise;
    logic [SER_LANES-1:0]              ser_fall;
    logic                              pclk;
    logic                              bclk;
    logic [PAR_W-1:0]                  par_rise;
    logic [PAR_W-1:0]                  par_fall;
    logic                              par_ck;
    logic                              fid_pend;
    logic [PAR_W-1:0]                  fid_word;
    logic                              vs_d;
    logic [NUM_MARK-1:0][HIST_W-1:0]   hist;
    logic [NUM_MARK-1:0]               marks;
  } dso_state_t;

  localparam dso_state_t STATE_RST = '{
    mode:     MODE_RST,
    mode_req: MODE_RST,
    default:  '0
  };

endpackage : dso_pkg

`default_nettype wire

/* dso_ddr_out.sv */
/*
  Double-data-rate output cell: drives the rise value while the clock is high
  and the fall value while it is low, one cycle after the values are given.
  Assumes a synchronised active-low reset and a clock enable on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module dso_ddr_out #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Data for each half cycle
  input  wire logic [W-1:0] d_rise,
  input  wire logic [W-1:0] d_fall,
  // Pin side
  output logic      [W-1:0] q
);

  logic [W-1:0] rise_ff;
  logic [W-1:0] fall_ff;
  logic [W-1:0] fall_neg_ff;

  // Capture both halves on the rising edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_ff <= '0;
      fall_ff <= '0;
    end
    else if (clk_en)
    begin
      rise_ff <= d_rise;
      fall_ff <= d_fall;
    end
  end

  // Retime the low half so the mux never glitches at the rising edge
  always_ff @(negedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fall_neg_ff <= '0;
    else
      fall_neg_ff <= fall_ff;
  end

  // Half-cycle select
  assign q = sys_clk ? rise_ff : fall_neg_ff;

endmodule : dso_ddr_out

`default_nettype wire

/* dso_host_model.sv */
/*
  Host capture model: rebuilds serial words from pixel clock edges and
  samples both halves of every cycle on the parallel link.
  Assumes the sensor outputs change only on sys_clk edges.
*/
`timescale 1ns/1ps
`default_nettype none

module dso_host_model
  import dso_pkg::*;
(
  // Clock and state
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    par_mode,
  // Serial link, lane 0 is pair a
  input  wire logic [2:0]              ser_p,
  input  wire logic [2:0]              ser_n,
  input  wire logic                    pclk_p,
  input  wire logic                    pclk_n,
  // Parallel link
  input  wire logic [PAR_W-1:0]        par_d,
  input  wire logic                    par_ck,
  // Captured results
  output int                           ser_cnt,
  output logic [2:0][WORD_W-1:0]       ser_w,
  output logic [PAR_W-1:0]             par_r,
  output logic [PAR_W-1:0]             par_f,
  output int                           err_cnt
);
  logic [2:0]             hi;
  logic                   pc;
  logic                   pc_prev = 1'b0;
  int                     idx = 7;
  logic [2:0][WORD_W-1:0] acc;

  initial
  begin
    ser_cnt = 0;
    err_cnt = 0;
  end

  // Sample high half, then low half, of every cycle
  always @(posedge sys_clk)
  begin
    #6;
    hi = ser_p;
    pc = pclk_p;
    par_r = par_d;
    if (rst_n && par_mode && par_ck !== 1'b1) err_cnt++;
    if (rst_n && (ser_n !== ~ser_p || pclk_n !== ~pclk_p)) err_cnt++;
    @(negedge sys_clk);
    #6;
    par_f = par_d;
    if (rst_n && par_mode && par_ck !== 1'b0) err_cnt++;
    // Falling pixel clock starts a word
    if (pc_prev && !pc) idx = 0;
    if (idx < 6)
    begin
      if (pc !== (idx >= 3)) err_cnt++;
      for (int l = 0; l < 3; l++)
      begin
        acc[l][2*idx] = hi[l];
        acc[l][2*idx+1] = ser_p[l];
      end
      idx++;
      if (idx == 6)
      begin
        ser_w = acc;
        ser_cnt++;
      end
    end
    pc_prev = pc;
  end
endmodule : dso_host_model

`default_nettype wire

/* dso_output_block_tb_top.sv */
/*
  Testbench for the depth sensor output block: markers, parallel and serial
  links with frame-ID words, judged through the host capture model.
  Assumes dso_pkg and dso_host_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module dso_output_block_tb_top
  import dso_pkg::*;
;
  logic                  sys_clk;
  logic                  nrst;
  logic                  serial_sel;
  logic                  clk_en;
  logic                  pix_valid;
  logic                  par_mode;
  logic [3:0]            ev;
  logic [3:0][DLY_W-1:0] dly;
  logic [3:0]            sf;
  logic [3:0]            qn;
  logic [WORD_W-1:0]     ta0, tb0, ta1, tb1, aux;
  wire  logic            pix_ready, fr, sfr, qd, rw;
  wire  logic [2:0]      sp, sn;
  wire  logic            pcp, pcn, pck, bck, bcn;
  wire  logic [PAR_W-1:0] pd;
  int                    fail_count = 0;
  int                    compares = 0;
  int                    cyc = 0;
  wire  logic [3:0]      mk = {rw, qd, sfr, fr};

  dso_output_block dut (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .serial_sel(serial_sel),
    .frame_mark_delay(dly[MK_FRAME]), .subframe_mark_delay(dly[MK_SUBF]),
    .quad_mark_delay(dly[MK_QUAD]), .row_mark_delay(dly[MK_ROW]),
    .frame_start_in(ev[MK_FRAME]), .subframe_start_in(ev[MK_SUBF]),
    .vertical_sync(ev[MK_QUAD]), .row_start_in(ev[MK_ROW]),
    .subframe_number(sf), .quad_number(qn), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .tap_a0(ta0), .tap_b0(tb0), .tap_a1(ta1),
    .tap_b1(tb1), .aux_word(aux), .frame_sync_out(fr), .subframe_sync_out(sfr),
    .quad_sync_out(qd), .row_sync_out(rw), .diff_data_pair_a_p(sp[0]),
    .diff_data_pair_a_n(sn[0]), .diff_data_pair_b_p(sp[1]),
    .diff_data_pair_b_n(sn[1]), .aux_data_pair_p(sp[2]), .aux_data_pair_n(sn[2]),
    .bit_clk_pair_p(bck), .bit_clk_pair_n(bcn), .pix_clk_pair_p(pcp),
    .pix_clk_pair_n(pcn), .par_data_out(pd), .par_clk_out(pck)
  );

  dso_host_model m (
    .sys_clk(sys_clk), .rst_n(nrst), .par_mode(par_mode), .ser_p(sp),
    .ser_n(sn), .pclk_p(pcp), .pclk_n(pcn), .par_d(pd), .par_ck(pck),
    .ser_cnt(), .ser_w(), .par_r(), .par_f(), .err_cnt()
  );

  // 40 MHz clock and hang guard
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // Raise vertical sync for two cycles with new numbers
  task automatic vs_pulse(input logic [3:0] s, input logic [3:0] q);
    @(negedge sys_clk);
    sf = s;
    qn = q;
    ev[MK_QUAD] = 1'b1;
    fork
      begin
        repeat (2) @(negedge sys_clk);
        ev[MK_QUAD] = 1'b0;
      end
    join_none
  endtask : vs_pulse

  // Offer one pixel and hold it until taken
  task automatic send_pix(input logic [WORD_W-1:0] a0, b0, a1, b1, ax);
    int n;
    @(negedge sys_clk);
    {ta0, tb0, ta1, tb1, aux} = {a0, b0, a1, b1, ax};
    pix_valid = 1'b1;
    #1;
    for (n = 0; n < 40 && pix_ready !== 1'b1; n++)
    begin
      @(negedge sys_clk);
      #1;
    end
    chk("pix_ready", 16'h1, {15'h0, pix_ready});
    @(negedge sys_clk);
    pix_valid = 1'b0;
  endtask : send_pix

  task automatic wait_par(input logic [PAR_W-1:0] r, f, input string nm);
    for (int n = 0; n < 10 && !(m.par_r === r && m.par_f === f); n++)
    begin
      @(negedge sys_clk);
      #8;
    end
    chk(nm, r, m.par_r);
    chk(nm, f, m.par_f);
  endtask : wait_par

  task automatic wait_ser(input logic [2:0][WORD_W-1:0] w, input string nm);
    int c;
    for (int n = 0; n < 8 && m.ser_w !== w; n++)
    begin
      c = m.ser_cnt;
      while (m.ser_cnt == c)
        @(posedge sys_clk);
    end
    for (int l = 0; l < 3; l++)
      chk(nm, 16'(w[l]), 16'(m.ser_w[l]));
  endtask : wait_ser

  // Marker latency d+1 and width of two cycles
  task automatic t_marker(input int i, input logic [DLY_W-1:0] d);
    int k;
    @(negedge sys_clk);
    dly[i] = d;
    @(negedge sys_clk);
    ev[i] = 1'b1;
    fork
      begin
        repeat (2) @(negedge sys_clk);
        ev[i] = 1'b0;
      end
    join_none
    for (k = 0; k < 20 && mk[i] !== 1'b1; k++)
    begin
      @(posedge sys_clk);
      #1;
    end
    chk("marker delay", 16'(d) + 16'h1, 16'(k));
    @(posedge sys_clk);
    #1;
    chk("marker high", 16'h1, {15'h0, mk[i]});
    @(posedge sys_clk);
    #1;
    chk("marker low", 16'h0, {15'h0, mk[i]});
  endtask : t_marker

  // Frame-ID leads a pixel on the parallel link
  task automatic t_parallel;
    vs_pulse(4'h3, 4'h9);
    fork
      send_pix(12'h9a5, 12'h123, 12'h005, 12'h00a, 12'h777);
      begin
        wait_par({FID_PAT, 8'h39}, {FID_PAT, 8'h39}, "par frame id");
        wait_par(16'h0882, 16'h0ffb, "par pixel");
      end
    join
  endtask : t_parallel

  // Frame-ID leads a pixel on the serial link
  task automatic t_serial;
    par_mode = 1'b0;
    serial_sel = 1'b1;
    vs_pulse(4'ha, 4'h5);
    fork
      send_pix(12'h0f0, 12'h0e1, 12'h100, 12'h200, 12'h5c3);
      begin
        wait_ser({12'h0, 12'h005, 12'h5a5}, "ser frame id");
        wait_ser({12'h5c3, 12'hf00, 12'h00f}, "ser pixel");
      end
    join
    chk("host model errors", 16'h0, 16'(m.err_cnt));
    // Bit clock pair follows sys_clk while serial
    @(posedge sys_clk);
    #6;
    chk("bit clock high", 16'h3, {14'h0, bck, ~bcn});
    @(negedge sys_clk);
    #6;
    chk("bit clock low", 16'h0, {14'h0, bck, ~bcn});
  endtask : t_serial

  // Enable low: events ignored, source refused
  task automatic t_freeze;
    @(negedge sys_clk);
    clk_en = 1'b0;
    ev[MK_ROW] = 1'b1;
    repeat (2) @(negedge sys_clk);
    ev[MK_ROW] = 1'b0;
    chk("ready while frozen", 16'h0, {15'h0, pix_ready});
    repeat (6) @(negedge sys_clk);
    chk("marker while frozen", 16'h0, {15'h0, rw});
    clk_en = 1'b1;
  endtask : t_freeze

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    serial_sel = 1'b0;
    clk_en = 1'b1;
    pix_valid = 1'b0;
    par_mode = 1'b0;
    ev = 4'h0;
    dly = '0;
    sf = 4'h0;
    qn = 4'h0;
    {ta0, tb0, ta1, tb1, aux} = '0;
    repeat (3) @(negedge sys_clk);
    chk("markers in reset", 16'h0, {12'h0, mk});
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (5) @(negedge sys_clk);
    par_mode = 1'b1;
    t_marker(MK_FRAME, 4'h0);
    t_marker(MK_SUBF, 4'h5);
    t_marker(MK_QUAD, 4'hf);
    t_marker(MK_ROW, 4'h2);
    t_freeze();
    t_parallel();
    t_serial();
    end_of_test();
  end
endmodule : dso_output_block_tb_top

`default_nettype wire
